// File: hdl/phy_regs_pkg.sv
// Constants, field positions and carrier types for the transceiver register group
package phy_regs_pkg;
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_PHY_RESET   = 10'h0D8;
  localparam logic [9:0] IDX_BASIC_CTRL  = 10'h0E4;
  localparam logic [9:0] IDX_BASIC_STAT  = 10'h0E6;
  localparam logic [9:0] IDX_ID_LOW      = 10'h0E8;
  localparam logic [9:0] IDX_ID_HIGH     = 10'h0EA;
  localparam logic [9:0] IDX_ADVERTISE   = 10'h0EC;
  localparam logic [9:0] IDX_PORT_CTRL   = 10'h0F6;
  localparam logic [9:0] IDX_IRQ_STATUS  = 10'h100;
  localparam logic [9:0] IDX_IRQ_CLEAR   = 10'h102;
  localparam logic [9:0] IDX_IRQ_ENABLE  = 10'h104;
  // Basic control field positions
  localparam int BC_LOOPBACK   = 14;
  localparam int BC_FORCE_100  = 13;
  localparam int BC_AN_ENABLE  = 12;
  localparam int BC_AN_RESTART = 9;
  localparam int BC_FULL_DUP   = 8;
  localparam int BC_MDIX_ALG   = 5;
  localparam int BC_MDIX_FORCE = 4;
  localparam int BC_MDIX_DIS   = 3;
  localparam int BC_TX_DIS     = 1;
  localparam int BC_LED_OFF    = 0;
  // Port control field positions
  localparam int PC_LED_OFF    = 15;
  localparam int PC_TX_DIS     = 14;
  localparam int PC_AN_RESTART = 13;
  localparam int PC_MDIX_DIS   = 10;
  localparam int PC_MDIX_FORCE = 9;
  localparam int PC_AN_ENABLE  = 7;
  localparam int PC_FORCE_100  = 6;
  localparam int PC_FULL_DUP   = 5;
  localparam int PC_PAUSE      = 4;
  // Advertisement field positions
  localparam int AD_PAUSE      = 10;
  localparam int AD_LO         = 5;
  localparam logic [4:0]  AD_SELECTOR   = 5'h01;
  // Fixed status pattern: 100/10 full/half and auto-negotiation capable
  localparam logic [15:0] STAT_FIXED    = 16'h7808;
  localparam int ST_AN_DONE    = 5;
  localparam int ST_LINK       = 2;
  // Identifier words, arbitrary values
  localparam logic [15:0] ID_LOW_CODE   = 16'hA5C3;
  localparam logic [15:0] ID_HIGH_CODE  = 16'h005A;
  // Interrupt status bits
  localparam int IRQ_LINK_CHG  = 0;
  localparam int IRQ_AN_DONE   = 1;
  localparam int IRQ_W         = 2;

  typedef struct packed {
    logic loopback;
    logic force_100;
    logic an_enable;
    logic full_duplex;
    logic crossover_algorithm_select;
    logic mdix_force;
    logic auto_mdix_disable;
    logic tx_disable;
    logic led_off;
  } ctrl_t;

  typedef struct packed {
    logic pause;
    logic adv_100_full;
    logic adv_100_half;
    logic adv_10_full;
    logic adv_10_half;
  } adv_t;

  localparam ctrl_t CTRL_RESET = '{loopback: 1'b0, force_100: 1'b1, an_enable: 1'b1,
                                   full_duplex: 1'b1, crossover_algorithm_select: 1'b1,
                                   mdix_force: 1'b0, auto_mdix_disable: 1'b0,
                                   tx_disable: 1'b0, led_off: 1'b0};
  localparam adv_t  ADV_RESET  = 5'h1F;
endpackage

// File: hdl/phy_port_control_status_regs.sv
// AHB-Lite register group controlling and reporting on the integrated transceiver
`timescale 1ns/1ps

// Summary of operation
// - Reset bit write pulses transceiver reset, self-clears
// - Control bit 14 loops host data back
// - Autoneg off: bit 13 picks 100/10
// - Control bit 9 write restarts autonegotiation
// - Control bit 8 picks full/half duplex
// - Control bit 5 selects crossover algorithm variant
// - Bit 3 disables auto crossover, 4 forces
// - Control bit 1 disables the transmitter
// - Control bit 0 turns all LEDs off
// - Status capability bits fixed, T4 zero
// - Status bit 5 shows negotiation complete
// - Status bit 2 shows live link state
// - Status bit 3 reads constant one
// - Extended, preamble, jabber bits read zero
// - Identifier readable as two fixed words
// - Advertisement bit 10 offers pause
// - Advertisement bits 8..5 offer abilities, fixed selector
module phy_port_control_status_regs
  import phy_regs_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  input  wire logic        i_link_up,
  input  wire logic        i_an_complete,
  output ctrl_t            o_ctrl,
  output adv_t             o_adv,
  output logic             o_phy_reset,
  output logic             o_an_restart,
  output logic             o_irq
);

  function automatic logic [31:0] byte_addr(input logic [9:0] idx);
    byte_addr = {20'h00000, idx, 2'b00};
  endfunction

  ctrl_t             ctrl_reg;
  adv_t              adv_reg;
  logic              wr_pend_reg;
  logic              rd_pend_reg;
  logic [31:0]       addr_reg;
  logic [31:0]       rdata_next;
  logic              wr_done;
  logic [15:0]       wdat;
  logic              link_meta_reg;
  logic              link_sync_reg;
  logic              link_prev_reg;
  logic              an_meta_reg;
  logic              an_sync_reg;
  logic              an_prev_reg;
  logic [IRQ_W-1:0]  irq_stat_reg;
  logic [IRQ_W-1:0]  irq_en_reg;
  logic [IRQ_W-1:0]  irq_event;
  logic              accept;

  assign accept  = i_hsel && i_htrans[1] && i_hready;
  assign wr_done = wr_pend_reg && i_hready;
  assign wdat    = i_hwdata[15:0];

  // Bus phase tracking; reads take one wait state so a write just before is seen
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= 32'h00000000;
      o_hreadyout <= 1'b1;
      o_hrdata    <= 32'h00000000;
    end else begin
      if (i_hready) begin
        wr_pend_reg <= accept && i_hwrite;
        rd_pend_reg <= accept && !i_hwrite;
        if (accept) begin
          addr_reg <= i_haddr;
        end
        o_hreadyout <= !(accept && !i_hwrite);
      end else if (rd_pend_reg) begin
        o_hrdata    <= rdata_next;
        o_hreadyout <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_hresp <= 1'b0;
    end else begin
      o_hresp <= 1'b0;
    end
  end

  // Read mux; unmapped addresses read zero with an OKAY answer
  always_comb begin
    rdata_next = 32'h00000000;
    case (addr_reg)
      byte_addr(IDX_BASIC_CTRL): begin
        rdata_next[BC_LOOPBACK]   = ctrl_reg.loopback;
        rdata_next[BC_FORCE_100]  = ctrl_reg.force_100;
        rdata_next[BC_AN_ENABLE]  = ctrl_reg.an_enable;
        rdata_next[BC_FULL_DUP]   = ctrl_reg.full_duplex;
        rdata_next[BC_MDIX_ALG]   = ctrl_reg.crossover_algorithm_select;
        rdata_next[BC_MDIX_FORCE] = ctrl_reg.mdix_force;
        rdata_next[BC_MDIX_DIS]   = ctrl_reg.auto_mdix_disable;
        rdata_next[BC_TX_DIS]     = ctrl_reg.tx_disable;
        rdata_next[BC_LED_OFF]    = ctrl_reg.led_off;
      end
      byte_addr(IDX_BASIC_STAT): begin
        rdata_next[15:0]       = STAT_FIXED;
        rdata_next[ST_AN_DONE] = an_sync_reg;
        rdata_next[ST_LINK]    = link_sync_reg;
      end
      byte_addr(IDX_ID_LOW):  rdata_next[15:0] = ID_LOW_CODE;
      byte_addr(IDX_ID_HIGH): rdata_next[15:0] = ID_HIGH_CODE;
      byte_addr(IDX_ADVERTISE): begin
        rdata_next[AD_PAUSE]         = adv_reg.pause;
        rdata_next[AD_LO+3:AD_LO]    = adv_reg[3:0];
        rdata_next[4:0]              = AD_SELECTOR;
      end
      byte_addr(IDX_PORT_CTRL): begin
        rdata_next[PC_LED_OFF]    = ctrl_reg.led_off;
        rdata_next[PC_TX_DIS]     = ctrl_reg.tx_disable;
        rdata_next[PC_MDIX_DIS]   = ctrl_reg.auto_mdix_disable;
        rdata_next[PC_MDIX_FORCE] = ctrl_reg.mdix_force;
        rdata_next[PC_AN_ENABLE]  = ctrl_reg.an_enable;
        rdata_next[PC_FORCE_100]  = ctrl_reg.force_100;
        rdata_next[PC_FULL_DUP]   = ctrl_reg.full_duplex;
        rdata_next[PC_PAUSE:0]    = adv_reg;
      end
      byte_addr(IDX_IRQ_STATUS): rdata_next[IRQ_W-1:0] = irq_stat_reg;
      byte_addr(IDX_IRQ_ENABLE): rdata_next[IRQ_W-1:0] = irq_en_reg;
      default: rdata_next = 32'h00000000;
    endcase
  end

  // One storage per control bit, written through either alias except loopback and crossover select, which only basic control writes
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wr_done && addr_reg == byte_addr(IDX_BASIC_CTRL)) begin
      ctrl_reg.loopback                   <= wdat[BC_LOOPBACK];
      ctrl_reg.force_100                  <= wdat[BC_FORCE_100];
      ctrl_reg.an_enable                  <= wdat[BC_AN_ENABLE];
      ctrl_reg.full_duplex                <= wdat[BC_FULL_DUP];
      ctrl_reg.crossover_algorithm_select <= wdat[BC_MDIX_ALG];
      ctrl_reg.mdix_force                 <= wdat[BC_MDIX_FORCE];
      ctrl_reg.auto_mdix_disable          <= wdat[BC_MDIX_DIS];
      ctrl_reg.tx_disable                 <= wdat[BC_TX_DIS];
      ctrl_reg.led_off                    <= wdat[BC_LED_OFF];
    end else if (wr_done && addr_reg == byte_addr(IDX_PORT_CTRL)) begin
      ctrl_reg.led_off           <= wdat[PC_LED_OFF];
      ctrl_reg.tx_disable        <= wdat[PC_TX_DIS];
      ctrl_reg.auto_mdix_disable <= wdat[PC_MDIX_DIS];
      ctrl_reg.mdix_force        <= wdat[PC_MDIX_FORCE];
      ctrl_reg.an_enable         <= wdat[PC_AN_ENABLE];
      ctrl_reg.force_100         <= wdat[PC_FORCE_100];
      ctrl_reg.full_duplex       <= wdat[PC_FULL_DUP];
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      adv_reg <= ADV_RESET;
    end else if (wr_done && addr_reg == byte_addr(IDX_ADVERTISE)) begin
      adv_reg <= {wdat[AD_PAUSE], wdat[AD_LO+3:AD_LO]};
    end else if (wr_done && addr_reg == byte_addr(IDX_PORT_CTRL)) begin
      adv_reg <= wdat[PC_PAUSE:0];
    end
  end

  assign o_ctrl = ctrl_reg;
  assign o_adv  = adv_reg;

  // Self-clearing strobes: reset and restart read back as zero
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_phy_reset  <= 1'b0;
      o_an_restart <= 1'b0;
    end else begin
      o_phy_reset  <= wr_done && addr_reg == byte_addr(IDX_PHY_RESET) && wdat[0];
      o_an_restart <= wr_done && ((addr_reg == byte_addr(IDX_BASIC_CTRL) &&
                                   wdat[BC_AN_RESTART]) ||
                                  (addr_reg == byte_addr(IDX_PORT_CTRL) &&
                                   wdat[PC_AN_RESTART]));
    end
  end

  // Pin inputs come from the transceiver's domain, so two flops first
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      link_meta_reg <= 1'b0;
      link_sync_reg <= 1'b0;
      link_prev_reg <= 1'b0;
      an_meta_reg   <= 1'b0;
      an_sync_reg   <= 1'b0;
      an_prev_reg   <= 1'b0;
    end else begin
      link_meta_reg <= i_link_up;
      link_sync_reg <= link_meta_reg;
      link_prev_reg <= link_sync_reg;
      an_meta_reg   <= i_an_complete;
      an_sync_reg   <= an_meta_reg;
      an_prev_reg   <= an_sync_reg;
    end
  end

  assign irq_event[IRQ_LINK_CHG] = link_sync_reg ^ link_prev_reg;
  assign irq_event[IRQ_AN_DONE]  = an_sync_reg && !an_prev_reg;

  // A new event wins over a clear landing in the same cycle
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      irq_stat_reg <= '0;
      irq_en_reg   <= '0;
      o_irq        <= 1'b0;
    end else begin
      if (wr_done && addr_reg == byte_addr(IDX_IRQ_CLEAR)) begin
        irq_stat_reg <= (irq_stat_reg & ~wdat[IRQ_W-1:0]) | irq_event;
      end else begin
        irq_stat_reg <= irq_stat_reg | irq_event;
      end
      if (wr_done && addr_reg == byte_addr(IDX_IRQ_ENABLE)) begin
        irq_en_reg <= wdat[IRQ_W-1:0];
      end
      o_irq <= |(irq_stat_reg & irq_en_reg);
    end
  end

  a_phy_reset_pulse: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (wr_done && addr_reg == byte_addr(IDX_PHY_RESET) && i_hwdata[0])
      |=> o_phy_reset ##1 !o_phy_reset)
    else $error("reset bit write did not give a single pulse");

  a_reset_keeps_ctrl: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    o_phy_reset |-> $stable(o_ctrl) && $stable(o_adv))
    else $error("transceiver reset disturbed control storage");

  a_loopback_write: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (wr_done && addr_reg == byte_addr(IDX_BASIC_CTRL))
      |=> o_ctrl.loopback == $past(i_hwdata[BC_LOOPBACK]))
    else $error("loopback bit not taken from write");

  a_loop_not_aliased: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (wr_done && addr_reg == byte_addr(IDX_PORT_CTRL))
      |=> o_ctrl.loopback == $past(o_ctrl.loopback))
    else $error("port control write changed loopback");

  a_speed_write: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (wr_done && addr_reg == byte_addr(IDX_BASIC_CTRL))
      |=> o_ctrl.force_100 == $past(i_hwdata[BC_FORCE_100]) &&
          o_ctrl.an_enable == $past(i_hwdata[BC_AN_ENABLE]))
    else $error("speed or negotiation enable not taken");

  a_restart_pulse: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (wr_done && addr_reg == byte_addr(IDX_BASIC_CTRL) && i_hwdata[BC_AN_RESTART])
      |=> o_an_restart ##1 !o_an_restart)
    else $error("restart write did not pulse once");

  a_restart_reads_zero: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (rd_pend_reg && !i_hready && addr_reg == byte_addr(IDX_BASIC_CTRL))
      |=> !o_hrdata[BC_AN_RESTART])
    else $error("restart bit did not read back as zero");

  a_duplex_write: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (wr_done && addr_reg == byte_addr(IDX_BASIC_CTRL))
      |=> o_ctrl.full_duplex == $past(i_hwdata[BC_FULL_DUP]))
    else $error("duplex bit not taken from write");

  a_xover_select: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (wr_done && addr_reg == byte_addr(IDX_BASIC_CTRL))
      |=> o_ctrl.crossover_algorithm_select == $past(i_hwdata[BC_MDIX_ALG]))
    else $error("crossover variant bit not taken");

  a_mdix_write: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (wr_done && addr_reg == byte_addr(IDX_BASIC_CTRL))
      |=> o_ctrl.mdix_force == $past(i_hwdata[BC_MDIX_FORCE]) &&
          o_ctrl.auto_mdix_disable == $past(i_hwdata[BC_MDIX_DIS]))
    else $error("crossover force or disable not taken");

  a_tx_disable: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (wr_done && addr_reg == byte_addr(IDX_BASIC_CTRL))
      |=> o_ctrl.tx_disable == $past(i_hwdata[BC_TX_DIS]))
    else $error("transmit disable bit not taken");

  a_led_off: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (wr_done && addr_reg == byte_addr(IDX_BASIC_CTRL))
      |=> o_ctrl.led_off == $past(i_hwdata[BC_LED_OFF]))
    else $error("led off bit not taken");

  a_status_fixed: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (rd_pend_reg && !i_hready && addr_reg == byte_addr(IDX_BASIC_STAT))
      |=> o_hreadyout && o_hrdata[15:11] == 5'h0F && o_hrdata[3] && !o_hrdata[0] &&
          o_hrdata[2] == $past(link_sync_reg))
    else $error("status read pattern wrong");

  a_an_done_read: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (rd_pend_reg && !i_hready && addr_reg == byte_addr(IDX_BASIC_STAT))
      |=> o_hrdata[ST_AN_DONE] == $past(an_sync_reg))
    else $error("negotiation complete bit wrong");

  a_an_done_latch: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    $rose(an_sync_reg) |-> irq_event[IRQ_AN_DONE] ##1 irq_stat_reg[IRQ_AN_DONE])
    else $error("negotiation complete not latched");

  a_status_capable: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (rd_pend_reg && !i_hready && addr_reg == byte_addr(IDX_BASIC_STAT))
      |=> o_hrdata[3])
    else $error("negotiation capable bit not one");

  a_status_unsup: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (rd_pend_reg && !i_hready && addr_reg == byte_addr(IDX_BASIC_STAT))
      |=> !o_hrdata[0] && !o_hrdata[1] && !o_hrdata[6])
    else $error("unsupported status bits not zero");

  a_id_low_read: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (rd_pend_reg && !i_hready && addr_reg == byte_addr(IDX_ID_LOW))
      |=> o_hrdata == {16'h0000, ID_LOW_CODE})
    else $error("identifier low word wrong");

  a_id_high_read: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (rd_pend_reg && !i_hready && addr_reg == byte_addr(IDX_ID_HIGH))
      |=> o_hrdata == {16'h0000, ID_HIGH_CODE})
    else $error("identifier high word wrong");

  a_port_alias: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (wr_done && addr_reg == byte_addr(IDX_PORT_CTRL))
      |=> o_ctrl.led_off == $past(i_hwdata[PC_LED_OFF]) &&
          o_adv == $past(i_hwdata[PC_PAUSE:0]))
    else $error("alias write did not reach shared storage");

  a_alias_ctrl_bits: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (wr_done && addr_reg == byte_addr(IDX_PORT_CTRL))
      |=> o_ctrl.tx_disable == $past(i_hwdata[PC_TX_DIS]) &&
          o_ctrl.auto_mdix_disable == $past(i_hwdata[PC_MDIX_DIS]) &&
          o_ctrl.mdix_force == $past(i_hwdata[PC_MDIX_FORCE]) &&
          o_ctrl.an_enable == $past(i_hwdata[PC_AN_ENABLE]) &&
          o_ctrl.force_100 == $past(i_hwdata[PC_FORCE_100]) &&
          o_ctrl.full_duplex == $past(i_hwdata[PC_FULL_DUP]))
    else $error("alias control bits not shared");

  a_restart_alias: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (wr_done && addr_reg == byte_addr(IDX_PORT_CTRL) && i_hwdata[PC_AN_RESTART])
      |=> o_an_restart)
    else $error("alias restart write did not pulse");

  a_adv_write: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (wr_done && addr_reg == byte_addr(IDX_ADVERTISE))
      |=> o_adv.pause == $past(i_hwdata[AD_PAUSE]) &&
          o_adv.adv_10_half == $past(i_hwdata[AD_LO]))
    else $error("advertisement bits not taken");

  a_adv_abilities: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (wr_done && addr_reg == byte_addr(IDX_ADVERTISE))
      |=> o_adv[3:0] == $past(i_hwdata[AD_LO+3:AD_LO]))
    else $error("advertised abilities not taken");

  a_adv_selector: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (rd_pend_reg && !i_hready && addr_reg == byte_addr(IDX_ADVERTISE))
      |=> o_hrdata[4:0] == AD_SELECTOR &&
          o_hrdata[AD_PAUSE] == $past(o_adv.pause))
    else $error("advertisement read pattern wrong");

  a_link_follows: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    $rose(link_sync_reg) |-> irq_event[IRQ_LINK_CHG] ##1 irq_stat_reg[IRQ_LINK_CHG])
    else $error("link change not latched");

endmodule

// File: verif/tb_phy_port_control_status_regs.sv
// Self-checking testbench for the transceiver register group
`timescale 1ns/1ps
module tb_phy_port_control_status_regs;
  import phy_regs_pkg::*;
  logic        i_clk;
  logic        i_arst_n;
  logic        i_hsel;
  logic [31:0] i_haddr;
  logic [1:0]  i_htrans;
  logic        i_hwrite;
  logic [2:0]  i_hsize;
  logic [31:0] i_hwdata;
  wire logic   i_hready;
  logic [31:0] o_hrdata;
  logic        o_hreadyout;
  logic        o_hresp;
  logic        i_link_up;
  logic        i_an_complete;
  ctrl_t       o_ctrl;
  adv_t        o_adv;
  logic        o_phy_reset;
  logic        o_an_restart;
  logic        o_irq;
  int          n_errors;
  int          comparisons;
  int          cycles;
  logic [31:0] d;
  logic [15:0] v;
  logic [15:0] cm;
  logic [4:0]  am;
  logic [9:0]  ri [6];
  logic [15:0] rx [6];

  phy_port_control_status_regs dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_hsel(i_hsel),
    .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize),
    .i_hwdata(i_hwdata), .i_hready(i_hready), .o_hrdata(o_hrdata),
    .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_link_up(i_link_up),
    .i_an_complete(i_an_complete), .o_ctrl(o_ctrl), .o_adv(o_adv),
    .o_phy_reset(o_phy_reset), .o_an_restart(o_an_restart), .o_irq(o_irq));
  // Single slave, so its ready is the bus ready
  assign i_hready = o_hreadyout;

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // Generous ceiling; the sequence needs well under two thousand cycles
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      $display("[FAIL] %0t timeout before the sequence finished", $time);
      n_errors++;
      complete_run();
    end
  end

  function automatic logic [31:0] addr(input logic [9:0] idx);
    addr = {20'h0, idx, 2'b00};
  endfunction
  function automatic ctrl_t ctrl_of(input logic [15:0] c);
    ctrl_of = {c[14], c[13], c[12], c[8], c[5], c[4], c[3], c[1], c[0]};
  endfunction
  function automatic logic [15:0] pc_img(input logic [15:0] c, input logic [4:0] a);
    pc_img = {c[0], c[1], 3'b000, c[3], c[4], 1'b0, c[12], c[13], c[8], a};
  endfunction
  function automatic logic [15:0] adv_img(input logic [4:0] a);
    adv_img = {5'h00, a[4], 1'b0, a[3:0], 5'h01};
  endfunction

  task automatic complete_run();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t word got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t flag got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic wait_ready();
    do @(posedge i_clk); while (o_hreadyout !== 1'b1);
  endtask
  task automatic bus_write(input logic [31:0] a, input logic [31:0] wd);
    @(posedge i_clk);
    i_hsel   <= 1'b1;
    i_htrans <= 2'b10;
    i_haddr  <= a;
    i_hwrite <= 1'b1;
    wait_ready();
    i_htrans <= 2'b00;
    i_hwdata <= wd;
    wait_ready();
  endtask
  task automatic bus_read(input logic [31:0] a, output logic [31:0] rd);
    @(posedge i_clk);
    i_hsel   <= 1'b1;
    i_htrans <= 2'b10;
    i_haddr  <= a;
    i_hwrite <= 1'b0;
    wait_ready();
    i_htrans <= 2'b00;
    wait_ready();
    rd = o_hrdata;
  endtask

  initial begin
    void'($urandom(32'h3DCE135E));
    {i_hsel, i_haddr, i_htrans, i_hwrite, i_hwdata} = '0;
    i_hsize = 3'b010;
    {i_link_up, i_an_complete, n_errors, comparisons, cycles} = '0;
    i_arst_n = 1'b0;
    repeat (10) @(posedge i_clk);
    i_arst_n <= 1'b1;
    #1;
    check_word({23'h0, o_ctrl}, {23'h0, CTRL_RESET});
    check_word({27'h0, o_adv}, 32'h0000001F);
    ri = '{IDX_BASIC_CTRL, IDX_BASIC_STAT, IDX_ID_LOW, IDX_ID_HIGH, IDX_ADVERTISE, IDX_PHY_RESET};
    rx = '{16'h3120, 16'h7808, ID_LOW_CODE, ID_HIGH_CODE, 16'h05E1, 16'h0000};
    foreach (ri[i]) begin
      bus_read(addr(ri[i]), d);
      check_word(d, {16'h0, rx[i]});
    end
    cm = 16'h3120;
    am = 5'h1F;
    // Both all-ones and all-zeros first, then random patterns
    for (int i = 0; i < 12; i++) begin
      v = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'($urandom);
      bus_write(addr(IDX_BASIC_CTRL), {16'h0, v});
      #1;
      check_bit(o_an_restart, v[9]);
      cm = v & 16'h713B;
      check_word({23'h0, o_ctrl}, {23'h0, ctrl_of(cm)});
      @(posedge i_clk);
      #1;
      check_bit(o_an_restart, 1'b0);
      bus_read(addr(IDX_BASIC_CTRL), d);
      check_word(d, {16'h0, cm});
      bus_read(addr(IDX_PORT_CTRL), d);
      check_word(d & 32'h0000E6FF, {16'h0, pc_img(cm, am)});
      v = 16'($urandom);
      bus_write(addr(IDX_PORT_CTRL), {16'h0, v});
      #1;
      check_bit(o_an_restart, v[13]);
      {cm[0], cm[1], cm[3], cm[4], cm[12], cm[13], cm[8]} = {v[15:14], v[10:9], v[7:5]};
      am = v[4:0];
      bus_read(addr(IDX_BASIC_CTRL), d);
      check_word(d, {16'h0, cm});
      bus_read(addr(IDX_ADVERTISE), d);
      check_word(d, {16'h0, adv_img(am)});
      v = 16'($urandom);
      bus_write(addr(IDX_ADVERTISE), {16'h0, v});
      am = {v[10], v[8:5]};
      bus_read(addr(IDX_ADVERTISE), d);
      check_word(d, {16'h0, adv_img(am)});
      check_word({27'h0, o_adv}, {27'h0, am});
    end
    bus_write(addr(IDX_PHY_RESET), 32'h0000FFFF);
    #1;
    check_bit(o_phy_reset, 1'b1);
    @(posedge i_clk);
    #1;
    check_bit(o_phy_reset, 1'b0);
    bus_read(addr(IDX_PHY_RESET), d);
    check_word(d, 32'h0);
    bus_read(addr(IDX_BASIC_CTRL), d);
    check_word(d, {16'h0, cm});
    // Link and negotiation events through the interrupt path
    bus_write(addr(IDX_IRQ_ENABLE), 32'h3);
    bus_write(addr(IDX_IRQ_CLEAR), 32'h3);
    i_link_up <= 1'b1;
    repeat (5) @(posedge i_clk);
    bus_read(addr(IDX_BASIC_STAT), d);
    check_word(d, 32'h780C);
    bus_read(addr(IDX_IRQ_STATUS), d);
    check_word(d, 32'h1);
    check_bit(o_irq, 1'b1);
    bus_write(addr(IDX_IRQ_CLEAR), 32'h1);
    bus_write(addr(IDX_IRQ_ENABLE), 32'h0);
    i_an_complete <= 1'b1;
    repeat (5) @(posedge i_clk);
    bus_read(addr(IDX_BASIC_STAT), d);
    check_word(d, 32'h782C);
    check_bit(o_irq, 1'b0);
    bus_write(addr(IDX_IRQ_ENABLE), 32'h2);
    repeat (2) @(posedge i_clk);
    #1;
    check_bit(o_irq, 1'b1);
    bus_write(addr(IDX_IRQ_CLEAR), 32'h3);
    bus_read(addr(IDX_IRQ_STATUS), d);
    check_word(d, 32'h0);
    check_bit(o_irq, 1'b0);
    i_link_up <= 1'b0;
    repeat (5) @(posedge i_clk);
    bus_read(addr(IDX_BASIC_STAT), d);
    check_word(d, 32'h7828);
    // Reserved hole reads zero and ignores writes
    bus_write(32'h0000036C, 32'hFFFFFFFF);
    bus_read(32'h0000036C, d);
    check_word(d, 32'h0);
    check_bit(o_hresp, 1'b0);
    complete_run();
  end
endmodule
